//--- digital_input_timing_engine.sv
// Digital input timing engine with APB registers and line control
// Behaviour
// [R1] Each line individually static input or output
// [R2] All lines are inputs after reset
// [R3] Finite mode stops at programmed sample count
// [R4] Continuous mode runs until software stop
// [R5] Each strobe edge writes port word
// [R6] Strobe while FIFO full flags overflow
// [R7] Strobe source internal or external, edge selectable
// [R8] Internal strobe choices with selectable polarity
// [R9] Any line usable as external strobe
// [R10] Exported strobe drives line inverted
// [R11] Strobes ignored outside an acquisition
// [R12] Engine generates strobe unless external source
// [R13] Programmable start delay, default two ticks
// [R14] Reference timebase selectable among four sources
// [R15] Divided reference is a strobe source
// [R16] Reference edge selectable except fast sources
// [R17] Software start when no begin source
// [R18] Retrigger repeats whole sequence per event; a sequence that finishes at delay end goes idle instead of rearming
// [R19] Begin events ignored while sequence runs
// [R20] Begin event source and edge selectable
// [R21] Exported begin event is active-high pulse
// [R22] External edges synchronised before use
//
// Design decisions made here: the placing of the registers and the APB register port.
`default_nettype none
module digital_input_timing_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] line_in,
    output logic [15:0] line_out,
    output logic [15:0] line_oe,
    input wire logic tick_100mhz,
    input wire logic tick_20mhz,
    input wire logic [7:0] internal_strobes,
    input wire logic counter_output,
    input wire logic change_detect_event,
    input wire logic analog_in_begin_event,
    input wire logic analog_out_begin_event,
    input wire logic output_word_begin_event,
    input wire logic fifo_full,
    output logic [15:0] fifo_wdata,
    output logic fifo_wvalid,
    output logic acq_running
);
    logic [31:0] mode, begin_cfg, sample_count, export_cfg, captured;
    logic [15:0] divisor, delay_ticks, line_dir, static_out, static_drive, static_in;
    logic [15:0] div_cnt, dly_cnt, line_sync_q, line_prev;
    logic [7:0] int_prev;
    logic [8:0] slow_cnt;
    logic slow_sq, slow_prev, overflow, done, begin_pulse;
    logic [4:0] begin_prev;
    dite_pkg::engine_state_t state;

    // Pin lines pass two flip-flops before any use
    line_sync #(.W(16)) u_sync (  // [R22]
        .pclk(pclk),
        .presetn(presetn),
        .d(line_in),
        .q(line_sync_q),
        .q_prev(line_prev)
    );

    // Bus decode
    logic wr_acc, setup, mapped, start_cmd, stop_cmd;
    assign wr_acc = psel & penable & pwrite;
    assign setup = psel & ~penable;
    assign pready = 1'b1;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= dite_pkg::OFF_EXPORT);
    assign pslverr = psel & penable & ~mapped;
    assign start_cmd = wr_acc && paddr == dite_pkg::OFF_CTRL && pwdata[dite_pkg::CMD_START];
    assign stop_cmd = wr_acc && paddr == dite_pkg::OFF_CTRL && pwdata[dite_pkg::CMD_STOP];

    // Configuration fields
    logic cont, retrig, ext, spol, rpol, bpol;
    logic [3:0] ssel, sline, rline, bline;
    logic [1:0] rsel;
    logic [2:0] bsrc;
    assign cont = mode[dite_pkg::M_CONT];
    assign retrig = mode[dite_pkg::M_RETRIG];
    assign ext = mode[dite_pkg::M_EXT];
    assign spol = mode[dite_pkg::M_SPOL];
    assign ssel = mode[dite_pkg::M_SSEL +: 4];
    assign sline = mode[dite_pkg::M_SLINE +: 4];
    assign rsel = mode[dite_pkg::M_RSEL +: 2];
    assign rpol = mode[dite_pkg::M_RPOL];
    assign rline = mode[dite_pkg::M_RLINE +: 4];
    assign bsrc = begin_cfg[dite_pkg::B_SRC +: 3];
    assign bline = begin_cfg[dite_pkg::B_LINE +: 4];
    assign bpol = begin_cfg[dite_pkg::B_POL];

    // Writable configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= dite_pkg::MODE_RST;
            begin_cfg <= '0;
            sample_count <= dite_pkg::COUNT_RST;
            divisor <= dite_pkg::DIV_RST;
            delay_ticks <= dite_pkg::DELAY_RST;
            line_dir <= '0;  // [R2]
            static_out <= '0;
            export_cfg <= '0;
        end else if (wr_acc) begin
            case (paddr)
                dite_pkg::OFF_MODE: mode <= pwdata;
                dite_pkg::OFF_BEGIN: begin_cfg <= pwdata;
                dite_pkg::OFF_COUNT: sample_count <= pwdata;
                dite_pkg::OFF_DIV: divisor <= pwdata[15:0];
                dite_pkg::OFF_DELAY: delay_ticks <= pwdata[15:0];
                dite_pkg::OFF_DIR: line_dir <= pwdata[15:0];  // [R1]
                dite_pkg::OFF_SOUT: static_out <= pwdata[15:0];
                dite_pkg::OFF_EXPORT: export_cfg <= pwdata;
                default: ;
            endcase
        end
    end

    // Static sample and update happen only on command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            static_in <= '0;
            static_drive <= '0;
        end else if (wr_acc && paddr == dite_pkg::OFF_CTRL) begin
            if (pwdata[dite_pkg::CMD_SAMPLE]) begin
                static_in <= line_sync_q;  // [R1]
            end
            if (pwdata[dite_pkg::CMD_UPDATE]) begin
                static_drive <= static_out;  // [R1]
            end
        end
    end

    // Read data is captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup && !pwrite) begin
            case (paddr)
                dite_pkg::OFF_MODE: prdata <= mode;
                dite_pkg::OFF_BEGIN: prdata <= begin_cfg;
                dite_pkg::OFF_COUNT: prdata <= sample_count;
                dite_pkg::OFF_DIV: prdata <= {16'h0000, divisor};
                dite_pkg::OFF_DELAY: prdata <= {16'h0000, delay_ticks};
                dite_pkg::OFF_DIR: prdata <= {16'h0000, line_dir};
                dite_pkg::OFF_SOUT: prdata <= {16'h0000, static_out};
                dite_pkg::OFF_SIN: prdata <= {16'h0000, static_in};
                dite_pkg::OFF_STATUS: prdata <= {28'h0000000, done, overflow,
                    state == dite_pkg::ST_ARMED, state == dite_pkg::ST_RUN};
                dite_pkg::OFF_DONE_CNT: prdata <= captured;
                dite_pkg::OFF_EXPORT: prdata <= export_cfg;
                default: prdata <= '0;
            endcase
        end
    end

    // Slow timebase and source edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt <= '0;
            slow_sq <= 1'b0;
            slow_prev <= 1'b0;
            int_prev <= '0;
            begin_prev <= '0;
        end else begin
            slow_cnt <= (slow_cnt == dite_pkg::SLOW_HALF - 9'h001) ? 9'h000 : slow_cnt + 9'h001;
            if (slow_cnt == dite_pkg::SLOW_HALF - 9'h001) begin
                slow_sq <= ~slow_sq;
            end
            slow_prev <= slow_sq;
            int_prev <= internal_strobes;
            begin_prev <= {counter_output, change_detect_event, analog_in_begin_event,
                analog_out_begin_event, output_word_begin_event};
        end
    end

    // Reference tick; no edge choice for fast sources
    logic ref_tick;
    always_comb begin
        case (rsel)
            dite_pkg::REF_100M: ref_tick = tick_100mhz;  // [R14] [R16]
            dite_pkg::REF_20M: ref_tick = tick_20mhz;  // [R14] [R16]
            dite_pkg::REF_100K: ref_tick = dite_pkg::edge_hit(slow_sq, slow_prev, rpol);  // [R16]
            default: ref_tick = dite_pkg::edge_hit(line_sync_q[rline], line_prev[rline], rpol);
        endcase
    end

    // Begin event from the selected source and edge
    logic begin_edge;
    always_comb begin
        case (bsrc)
            dite_pkg::BSRC_LINE:
                begin_edge = dite_pkg::edge_hit(line_sync_q[bline], line_prev[bline], bpol);  // [R20]
            dite_pkg::BSRC_CNT:
                begin_edge = dite_pkg::edge_hit(counter_output, begin_prev[4], bpol);
            dite_pkg::BSRC_CHG:
                begin_edge = dite_pkg::edge_hit(change_detect_event, begin_prev[3], bpol);
            dite_pkg::BSRC_AI:
                begin_edge = dite_pkg::edge_hit(analog_in_begin_event, begin_prev[2], bpol);
            dite_pkg::BSRC_AO:
                begin_edge = dite_pkg::edge_hit(analog_out_begin_event, begin_prev[1], bpol);
            dite_pkg::BSRC_DO:
                begin_edge = dite_pkg::edge_hit(output_word_begin_event, begin_prev[0], bpol);
            default: begin_edge = 1'b0;
        endcase
    end

    // Generated strobe: delay end, then every divisor ticks
    logic gen_pulse, delay_end, div_wrap, use_gen, capture_edge, capture_take, finish;
    assign use_gen = !ext && ssel == dite_pkg::SSEL_DIVIDED;  // [R12]
    assign delay_end = state == dite_pkg::ST_DELAY && ref_tick
        && (delay_ticks <= 16'h0001 || dly_cnt == delay_ticks - 16'h0001);  // [R13]
    assign div_wrap = state == dite_pkg::ST_RUN && ref_tick
        && (divisor <= 16'h0001 || div_cnt == divisor - 16'h0001);  // [R15]
    assign gen_pulse = delay_end || div_wrap;

    // Strobe edge from the chosen source
    always_comb begin
        if (ext) begin
            capture_edge = dite_pkg::edge_hit(line_sync_q[sline], line_prev[sline], spol);  // [R9]
        end else if (use_gen) begin
            capture_edge = gen_pulse;  // [R12]
        end else begin
            capture_edge = dite_pkg::edge_hit(internal_strobes[ssel[2:0]],
                int_prev[ssel[2:0]], spol);  // [R7] [R8]
        end
    end
    assign capture_take = capture_edge && (state == dite_pkg::ST_RUN || delay_end);  // [R11]
    assign finish = capture_take && !cont && (captured + 32'h1 >= sample_count);  // [R3] [R4]
    assign acq_running = state == dite_pkg::ST_RUN || state == dite_pkg::ST_DELAY;

    // Sequence state machine; stop command wins over everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= dite_pkg::ST_IDLE;
            begin_pulse <= 1'b0;
        end else begin
            begin_pulse <= 1'b0;
            if (stop_cmd) begin
                state <= dite_pkg::ST_IDLE;  // [R4]
            end else begin
                case (state)
                    dite_pkg::ST_IDLE: if (start_cmd) begin
                        if (bsrc == dite_pkg::BSRC_NONE) begin
                            state <= use_gen ? dite_pkg::ST_DELAY : dite_pkg::ST_RUN;  // [R17]
                            begin_pulse <= 1'b1;
                        end else begin
                            state <= dite_pkg::ST_ARMED;
                        end
                    end
                    dite_pkg::ST_ARMED: if (begin_edge) begin
                        state <= use_gen ? dite_pkg::ST_DELAY : dite_pkg::ST_RUN;  // [R20]
                        begin_pulse <= 1'b1;
                    end
                    dite_pkg::ST_DELAY: if (delay_end) begin
                        state <= finish ? dite_pkg::ST_IDLE : dite_pkg::ST_RUN;  // [R13]
                    end
                    dite_pkg::ST_RUN: if (finish) begin
                        // Begin events in RUN fall through unseen
                        state <= (retrig && bsrc != dite_pkg::BSRC_NONE)
                            ? dite_pkg::ST_ARMED : dite_pkg::ST_IDLE;  // [R3] [R18] [R19]
                    end
                    default: state <= dite_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Counters restart with each sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_cnt <= '0;
            div_cnt <= '0;
            captured <= '0;
        end else begin
            if (state != dite_pkg::ST_DELAY) begin
                dly_cnt <= '0;
            end else if (ref_tick) begin
                dly_cnt <= dly_cnt + 16'h0001;
            end
            if (state != dite_pkg::ST_RUN || div_wrap) begin
                div_cnt <= '0;
            end else if (ref_tick) begin
                div_cnt <= div_cnt + 16'h0001;
            end
            if (begin_pulse) begin
                captured <= '0;  // [R18]
            end else if (capture_take) begin
                captured <= captured + 32'h1;
            end
        end
    end

    // FIFO write of the whole port, or overflow when full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_wvalid <= 1'b0;
            fifo_wdata <= '0;
        end else begin
            fifo_wvalid <= capture_take && !fifo_full;  // [R5] [R6]
            if (capture_take) begin
                fifo_wdata <= line_sync_q;  // [R5]
            end
        end
    end

    // Sticky flags, write one to clear; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow <= 1'b0;
            done <= 1'b0;
        end else begin
            if (capture_take && fifo_full) begin
                overflow <= 1'b1;  // [R6]
            end else if (wr_acc && paddr == dite_pkg::OFF_STATUS && pwdata[dite_pkg::S_OVF]) begin
                overflow <= 1'b0;
            end
            if (finish) begin
                done <= 1'b1;
            end else if (wr_acc && paddr == dite_pkg::OFF_STATUS && pwdata[dite_pkg::S_DONE]) begin
                done <= 1'b0;
            end
        end
    end

    // Pin drive: static lines, then exported strobe and begin event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_out <= '0;
            line_oe <= '0;  // [R2]
        end else begin
            line_out <= static_drive;
            line_oe <= line_dir;  // [R1]
            if (export_cfg[dite_pkg::E_SEN]) begin
                line_out[export_cfg[dite_pkg::E_SLINE +: 4]] <= ~capture_take;  // [R10]
                line_oe[export_cfg[dite_pkg::E_SLINE +: 4]] <= 1'b1;
            end
            if (export_cfg[dite_pkg::E_BEN]) begin
                line_out[export_cfg[dite_pkg::E_BLINE +: 4]] <= begin_pulse;  // [R21]
                line_oe[export_cfg[dite_pkg::E_BLINE +: 4]] <= 1'b1;
            end
        end
    end

    // Checks
    logic first_cycle;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_inputs_after_reset: assert property (first_cycle |-> line_oe == '0)  // [R2]
        else $error("line driven right after reset");
    a_dir_to_oe: assert property ((export_cfg[dite_pkg::E_SEN] == 1'b0
        && export_cfg[dite_pkg::E_BEN] == 1'b0) |=> line_oe == $past(line_dir))  // [R1]
        else $error("output enable does not follow direction");
    a_finite_stop: assert property (finish && !stop_cmd |=> state != dite_pkg::ST_RUN)  // [R3]
        else $error("finite run kept going");
    a_cont_runs: assert property (state == dite_pkg::ST_RUN && cont && !stop_cmd
        |=> state == dite_pkg::ST_RUN)  // [R4]
        else $error("continuous run stopped without command");
    a_capture_write: assert property (capture_take && !fifo_full
        |=> fifo_wvalid && fifo_wdata == $past(line_sync_q))  // [R5]
        else $error("sample not written");
    a_overflow_flag: assert property (capture_take && fifo_full |=> overflow && !fifo_wvalid)  // [R6]
        else $error("overflow not flagged");
    a_idle_no_write: assert property (!acq_running |=> !fifo_wvalid)  // [R11]
        else $error("write outside acquisition");
    a_delay_holds: assert property (state == dite_pkg::ST_DELAY && !ref_tick && !stop_cmd
        |=> state == dite_pkg::ST_DELAY)  // [R13]
        else $error("delay ended without a tick");
    a_begin_ignored: assert property (state == dite_pkg::ST_RUN && !finish && !stop_cmd
        |=> state == dite_pkg::ST_RUN && !begin_pulse)  // [R19]
        else $error("begin event taken while running");
    a_strobe_export: assert property (export_cfg[dite_pkg::E_SEN] && capture_take
        |=> !line_out[$past(export_cfg[dite_pkg::E_SLINE +: 4])])  // [R10]
        else $error("exported strobe not inverted");

    c_finite_done: cover property (finish ##1 state == dite_pkg::ST_IDLE);
    c_overflow: cover property (capture_take && fifo_full);
    c_retrigger: cover property (finish ##1 state == dite_pkg::ST_ARMED);
    c_delay_run: cover property (delay_end ##1 state == dite_pkg::ST_RUN);
endmodule
`default_nettype wire

//--- dite_pkg.sv
// Constants and types for the digital input timing engine
`default_nettype none
package dite_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_BEGIN = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0c;
    localparam logic [7:0] OFF_DIV = 8'h10;
    localparam logic [7:0] OFF_DELAY = 8'h14;
    localparam logic [7:0] OFF_DIR = 8'h18;
    localparam logic [7:0] OFF_SOUT = 8'h1c;
    localparam logic [7:0] OFF_SIN = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_DONE_CNT = 8'h28;
    localparam logic [7:0] OFF_EXPORT = 8'h2c;
    // Command bits in CTRL
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_SAMPLE = 2;
    localparam int CMD_UPDATE = 3;
    // MODE fields
    localparam int M_CONT = 0;
    localparam int M_RETRIG = 1;
    localparam int M_EXT = 2;
    localparam int M_SPOL = 3;
    localparam int M_SSEL = 4;
    localparam int M_SLINE = 8;
    localparam int M_RSEL = 12;
    localparam int M_RPOL = 16;
    localparam int M_RLINE = 20;
    localparam logic [3:0] SSEL_DIVIDED = 4'h8;
    // Reference timebase choices
    localparam logic [1:0] REF_100M = 2'h0;
    localparam logic [1:0] REF_20M = 2'h1;
    localparam logic [1:0] REF_100K = 2'h2;
    localparam logic [1:0] REF_LINE = 2'h3;
    // BEGIN fields and source codes
    localparam int B_SRC = 0;
    localparam int B_LINE = 4;
    localparam int B_POL = 8;
    localparam logic [2:0] BSRC_NONE = 3'h0;
    localparam logic [2:0] BSRC_LINE = 3'h1;
    localparam logic [2:0] BSRC_CNT = 3'h2;
    localparam logic [2:0] BSRC_CHG = 3'h3;
    localparam logic [2:0] BSRC_AI = 3'h4;
    localparam logic [2:0] BSRC_AO = 3'h5;
    localparam logic [2:0] BSRC_DO = 3'h6;
    // EXPORT fields
    localparam int E_SEN = 0;
    localparam int E_SLINE = 4;
    localparam int E_BEN = 8;
    localparam int E_BLINE = 12;
    // STATUS bits
    localparam int S_RUN = 0;
    localparam int S_ARMED = 1;
    localparam int S_OVF = 2;
    localparam int S_DONE = 3;
    // Reset values
    localparam logic [31:0] MODE_RST = 32'h0000_0080;
    localparam logic [31:0] COUNT_RST = 32'h0000_0001;
    localparam logic [15:0] DIV_RST = 16'h0002;
    localparam logic [15:0] DELAY_RST = 16'h0002;
    // Slow timebase made from the bus clock
    localparam int CLK_HZ = 50_000_000;
    localparam int SLOW_HZ = 100_000;
    localparam logic [8:0] SLOW_HALF = 9'(CLK_HZ / (2 * SLOW_HZ));
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_DELAY = 2'b10,
        ST_RUN = 2'b11
    } engine_state_t;
    // Edge of a level against its previous value, falling when fall is set
    function automatic logic edge_hit(input logic cur, input logic prev, input logic fall);
        return fall ? (prev & ~cur) : (cur & ~prev);
    endfunction
endpackage
`default_nettype wire

//--- ext_sources.sv
// Model of the outside pins and the on-board timing sources
`default_nettype none
module ext_sources (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] line_out,
    input wire logic [15:0] line_oe,
    input wire logic [15:0] ext_level,
    output logic [15:0] line_in,
    output logic tick_100mhz,
    output logic tick_20mhz,
    output logic [7:0] internal_strobes,
    output logic counter_output,
    output logic change_detect_event
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div5;
    // Pin level: device drive or outside source
    assign line_in = (line_oe & line_out) | (~line_oe & ext_level);
    assign tick_100mhz = 1'b1;
    assign tick_20mhz = (div5 == 3'h4);
    assign counter_output = internal_strobes[3];
    assign change_detect_event = internal_strobes[6];
    // Fifth-cycle tick and free-running strobe levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div5 <= 3'h0;
            internal_strobes <= 8'h00;
        end else begin
            div5 <= (div5 == 3'h4) ? 3'h0 : div5 + 3'h1;
            internal_strobes <= internal_strobes + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- line_sync.sv
// Two-stage synchroniser with a delayed copy for edge detection
`default_nettype none
module line_sync #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] q_prev
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q <= '0;
            q_prev <= '0;
        end else begin
            meta <= d;
            q <= meta;
            q_prev <= q;
        end
    end
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the digital input timing engine
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, t100, t20, cnt_out, chg_ev, fifo_wvalid, acq_running, ev;
    logic fifo_full = 1'b0, ai_begin = 1'b0;
    logic [15:0] line_in, line_out, line_oe, fifo_wdata, ext_level = 16'h5a3c;
    logic [7:0] istr;
    int fail_count, tests_run, cyc, wcount, lows, highs, c0, l0, h0;
    logic [7:0] ra [5] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] rvals [5] = '{32'h80, 32'h1, 32'h2, 32'h2, 32'h0};
    always #10 pclk = ~pclk;
    // Design and its outside world
    digital_input_timing_engine DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .tick_100mhz(t100), .tick_20mhz(t20), .internal_strobes(istr),
        .counter_output(cnt_out), .change_detect_event(chg_ev),
        .analog_in_begin_event(ai_begin), .analog_out_begin_event(1'b0),
        .output_word_begin_event(1'b0), .fifo_full(fifo_full), .fifo_wdata(fifo_wdata),
        .fifo_wvalid(fifo_wvalid), .acq_running(acq_running));
    ext_sources pins (.pclk(pclk), .presetn(presetn), .line_out(line_out), .line_oe(line_oe),
        .ext_level(ext_level), .line_in(line_in), .tick_100mhz(t100), .tick_20mhz(t20),
        .internal_strobes(istr), .counter_output(cnt_out), .change_detect_event(chg_ev));
    // Count captures and export pulses
    always @(negedge pclk) begin
        if (fifo_wvalid === 1'b1) wcount++;
        if (line_oe[5] === 1'b1 && line_out[5] === 1'b0) lows++;
        if (line_oe[9] === 1'b1 && line_out[9] === 1'b1) highs++;
    end
    // Cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer, released after pready is seen
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string name);
        apb(1'b0, a, 32'h0);
        chk(name, e, rv & m);
    endtask
    task cyc_wait(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task results();
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ra[i]) rd(ra[i], 32'hffffffff, rvals[i], "reset value");
        chk("line_oe", 32'h0, {16'h0, line_oe});
        rd(8'h30, 32'hffffffff, 32'h0, "unmapped read");
        chk("pslverr", 32'h1, {31'h0, ev});
        wr(8'h0c, 32'h3);
        c0 = wcount;
        wr(8'h00, 32'h1);
        cyc_wait(40);
        chk("finite captures", 32'h3, 32'(wcount - c0));
        chk("captured word", 32'h5a3c, {16'h0, fifo_wdata});
        rd(8'h28, 32'hffffffff, 32'h3, "done count");
        rd(8'h24, 32'hf, 32'h8, "status finite");
        // Internal sources, continuous, then idle
        for (int s = 0; s < 8; s++) begin
            wr(8'h04, 32'h1 | (s << 4));
            c0 = wcount;
            wr(8'h00, 32'h1);
            cyc_wait(1100);
            chk("internal source", 32'h1, 32'(wcount - c0 > 3));
            wr(8'h00, 32'h2);
        end
        c0 = wcount;
        cyc_wait(300);
        chk("idle captures", 32'h0, 32'(wcount - c0));
        // 20 MHz reference rate, then overflow and stop
        wr(8'h24, 32'hc);
        wr(8'h04, 32'h1081);
        wr(8'h00, 32'h1);
        cyc_wait(30);
        c0 = wcount;
        cyc_wait(100);
        chk("20 MHz rate", 32'h1, 32'(wcount - c0 inside {[9:11]}));
        fifo_full <= 1'b1;
        cyc_wait(30);
        fifo_full <= 1'b0;
        rd(8'h24, 32'h5, 32'h5, "status overflow");
        wr(8'h00, 32'h2);
        cyc_wait(4);
        chk("running after stop", 32'h0, {31'h0, acq_running});
        // External line 3 as strobe, both edges
        wr(8'h0c, 32'h2);
        for (int p = 0; p < 2; p++) begin
            wr(8'h04, 32'h384 | (p << 3));
            c0 = wcount;
            wr(8'h00, 32'h1);
            repeat (3) begin
                ext_level[3] <= p[0];
                cyc_wait(8);
                ext_level[3] <= ~p[0];
                cyc_wait(8);
            end
            chk("ext captures", 32'h2, 32'(wcount - c0));
        end
        // Static output and sample commands
        wr(8'h18, 32'hff);
        wr(8'h1c, 32'h1234);
        wr(8'h00, 32'h8);
        cyc_wait(2);
        chk("static oe", 32'hff, {16'h0, line_oe});
        chk("static out", 32'h34, {24'h0, line_out[7:0]});
        wr(8'h00, 32'h4);
        rd(8'h20, 32'hffff, 32'h5a34, "static sample");
        // Retriggered run with both exports
        wr(8'h2c, 32'h9151);
        wr(8'h08, 32'h4);
        wr(8'h04, 32'h82);
        wr(8'h00, 32'h1);
        rd(8'h24, 32'h3, 32'h2, "armed");
        for (int i = 0; i < 2; i++) begin
            c0 = wcount;
            l0 = lows;
            h0 = highs;
            ai_begin <= 1'b1;
            cyc_wait(1);
            ai_begin <= 1'b0;
            if (i == 1) begin
                cyc_wait(3);
                ai_begin <= 1'b1;
                cyc_wait(1);
                ai_begin <= 1'b0;
            end
            cyc_wait(30);
            chk("retrig captures", 32'h2, 32'(wcount - c0));
            chk("strobe export lows", 32'h2, 32'(lows - l0));
            chk("begin export highs", 32'h1, 32'(highs - h0));
            rd(8'h24, 32'h3, 32'h2, "rearmed");
        end
        results();
    end
endmodule
`default_nettype wire
